// >>> verilog/vfd_scanner.sv
`timescale 1ns/1ps
`include "vfd_defs.svh"
// Function
// R1: thirty-seven display outputs, 0-15 large current, 16-36 middle current.
// R2: one to sixteen scan slots, count chosen by software.
// R3: five-bit pin select claims output groups; others stay general purpose.
// R4: scanner fetches 80-byte buffer itself without processor help.
// R5: eight brightness levels shorten the lit part of each slot.
// R6: slot time selectable fc/4096, fc/2048, fc/1024, fc/512.
// R7: entering slow or stop sets blank and clears enable key.
// R8: forced blank keeps other settings; outputs zero as pulled-down ports.
// R9: buffer spans addresses 0F80 to 0FCF, five columns of sixteen.
// R10: slot n drives column base plus n onto its output group.
// R11: a one bit lights its output during the slot, zero leaves off.
// R12: clearing blank starts scanning with current settings and buffer.
// R13: software keeps blank set while programming the settings.
// R14: software sets slot count to the tube's digit count.
// R15: readable status shows the driver's current state.
// R16: software keeps the buffer region for display only.
// R17: conventional tubes get one digit per slot, in sequence.
// R18: every set bit in a slot is driven together.
// R19: slots step 0 to count minus one and wrap while unblanked; code steps 0 to scan_slot_count itself, then wraps.
module vfd_scanner
   import vfd_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // buffer write port from processor
   input  wire logic        buf_wr,
   input  wire logic [11:0] buf_addr,
   input  wire logic [7:0]  buf_wdata,
   output logic [7:0]       buf_rdata,
   // control register one fields
   input  wire logic        blank_set,
   input  wire logic        blank_clr,
   input  wire logic        key_set,
   input  wire logic [1:0]  slot_time_sel,
   input  wire logic [4:0]  driver_pin_select,
   // control register two fields
   input  wire logic [2:0]  brightness_duty,
   input  wire logic [3:0]  scan_slot_count,
   // chip mode change to slow or stop
   input  wire logic        low_power_entry,
   // general purpose port latch for pins not claimed
   input  wire logic [36:0] port_latch,
   // display side
   output logic [36:0]      high_voltage_outputs,
   output logic [36:0]      driver_claimed,
   // status
   output logic             blank_control,
   output logic             display_enable_key,
   output logic [3:0]       current_slot,
   output logic [2:0]       display_driver_status
);

   logic [7:0]    mem [0:`VFD_BUF_BYTES-1];
   logic [3:0]    slot_q;
   logic [3:0]    slot_d;
   vfd_state_type state_q;
   vfd_state_type state_d;
   logic          run;
   logic          slot_end;
   logic          lit;
   logic          in_buf;
   logic [6:0]    wr_idx;
   logic [36:0]   slot_bits;
   logic [36:0]   claim;
   logic [36:0]   hv_d;
   logic [4:0]    pinsel_q;
   logic          low_q;
   logic          forced;
   logic [36:0]   lit_bits;
   logic [36:0]   gp_bits;

   // buffer index of a byte address
   function automatic logic [6:0] buf_index(input logic [11:0] a);
      logic [11:0] off;
      off = a - 12'(`VFD_BUF_BASE);
      buf_index = off[6:0];
   endfunction

   // buffer read index of column c at slot s
   function automatic logic [6:0] col_index(input int c,
                                            input logic [3:0] s);
      col_index = 7'(c * `VFD_COL_STRIDE) + {3'b000, s};
   endfunction

   // address decode for the buffer window
   assign in_buf = (buf_addr >= 12'(`VFD_BUF_BASE)) &&
                   (buf_addr <= 12'(`VFD_BUF_LAST));                   // R9
   assign wr_idx = buf_index(buf_addr);

   // buffer storage written by processor; no reset, so software must
   // fill every slot in use before it clears blank
   always_ff @(posedge sys_clk) begin
      if (buf_wr && in_buf) begin
         mem[wr_idx] <= buf_wdata;                                     // R9
      end
   end

   // processor readback, zero outside the window
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         buf_rdata <= 8'h00;
      end else begin
         buf_rdata <= in_buf ? mem[wr_idx] : 8'h00;
      end
   end

   // slot data fetch: five column bytes, last one five bits
   // column four feeds only five pins, its top three bits are unused
   assign slot_bits = {mem[col_index(4, slot_q)][4:0],
                       mem[col_index(3, slot_q)],
                       mem[col_index(2, slot_q)],
                       mem[col_index(1, slot_q)],
                       mem[col_index(0, slot_q)]};                     // R4 R10

   // pin select: bit k claims group k (8,8,8,8,5 pins)
   assign claim = {{5{pinsel_q[4]}}, {8{pinsel_q[3]}}, {8{pinsel_q[2]}},
                   {8{pinsel_q[1]}}, {8{pinsel_q[0]}}};                // R3

   // scan sequencing controls
   // the pointer parks at slot 0 while not scanning, so every restart
   // begins at the first slot
   assign run    = (state_q == VFD_SCAN);
   assign slot_d = !run ? 4'h0 :
                   !slot_end ? slot_q :
                   (slot_q >= scan_slot_count) ? 4'h0 :
                   slot_q + 4'h1;                                      // R19 R2

   // state: force blank on low-power entry, scan when unblanked
   // the forced state holds until software clears blank again
   always_comb begin
      state_d = state_q;
      case (state_q)
         VFD_IDLE:  if (!blank_control) state_d = VFD_SCAN;            // R12
         VFD_SCAN:  if (blank_control) state_d = VFD_IDLE;
         VFD_FORCE: if (!blank_control) state_d = VFD_SCAN;
         default:   state_d = VFD_IDLE;
      endcase
      if (low_q) state_d = VFD_FORCE;                                  // R7
   end

   // claimed set bits of a slot lit together, gated by dimmer window
   assign lit_bits = claim & slot_bits & {37{lit}};           // R11 R18
   // pins left unclaimed follow the general purpose port latch, except in forced blank where they are driven low
   assign gp_bits  = ~claim & port_latch;                     // R3
   // forced blank pulls every pin low until blank is cleared
   assign forced   = (state_q == VFD_FORCE);                  // R8
   assign hv_d     = forced ? 37'h0 :
                     run    ? (lit_bits | gp_bits) : gp_bits; // R8

   vfd_slot_timer u_timer (
      .sys_clk         (sys_clk),
      .rst             (rst),
      .run             (run),
      .slot_time_sel   (slot_time_sel),
      .brightness_duty (brightness_duty),
      .slot_end        (slot_end),
      .lit             (lit)
   );

   // settings follow their inputs; a forced blank leaves them alone
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pinsel_q <= `VFD_PINSEL_RST;
         low_q    <= 1'b0;
      end else begin
         pinsel_q <= driver_pin_select;                        // R8
         low_q    <= low_power_entry;
      end
   end

   // control bits: forced blank wins over software writes
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         blank_control      <= `VFD_BLANK_RST;
         display_enable_key <= 1'b0;
      end else if (low_power_entry) begin
         blank_control      <= 1'b1;                           // R7
         display_enable_key <= 1'b0;                           // R7
      end else begin
         if (blank_set) blank_control <= 1'b1;
         else if (blank_clr) blank_control <= 1'b0;            // R12
         if (key_set) display_enable_key <= 1'b1;
      end
   end

   // scan state and slot pointer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= VFD_IDLE;
         slot_q  <= 4'h0;
      end else begin
         state_q <= state_d;
         slot_q  <= slot_d;
      end
   end

   // pin levels and claim mask, registered straight to the pins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         high_voltage_outputs <= 37'h0;                        // R1
         driver_claimed       <= 37'h0;
      end else begin
         high_voltage_outputs <= hv_d;                         // R1
         driver_claimed       <= forced ? 37'h0 : claim;       // R8
      end
   end

   // status copies, one cycle ahead of the pins on purpose
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         current_slot          <= 4'h0;
         display_driver_status <= 3'h0;
      end else begin
         current_slot          <= slot_d;
         display_driver_status <= state_d;                     // R15
      end
   end
endmodule // vfd_scanner

// >>> verilog/vfd_defs.svh
`ifndef VFD_DEFS_SVH
`define VFD_DEFS_SVH
// buffer layout
`define VFD_BUF_BASE      12'hF80
`define VFD_BUF_LAST      12'hFCF
`define VFD_BUF_BYTES     80
`define VFD_COL_STRIDE    16
`define VFD_NUM_COLS      5
`define VFD_NUM_SLOTS     16
`define VFD_NUM_OUT       37
`define VFD_LARGE_OUTS    16
`define VFD_MID_OUTS      21
// slot time selects: divide exponents 12 down to 9
`define VFD_DIV_EXP_MAX   12
`define VFD_DIV_EXP_MIN   9
// dimmer: eight steps of the slot length, in sixteenths
`define VFD_DIM_STEPS     8
`define VFD_DIM_DEN       16
// reset values
`define VFD_BLANK_RST     1'b1
`define VFD_PINSEL_RST    5'h00
`endif

// >>> verilog/vfd_pkg.sv
package vfd_pkg;
   typedef enum logic [2:0] {
      VFD_IDLE  = 3'b001,
      VFD_SCAN  = 3'b010,
      VFD_FORCE = 3'b100
   } vfd_state_type;
endpackage

// >>> verilog/vfd_slot_timer.sv
`timescale 1ns/1ps
`include "vfd_defs.svh"
// counts one slot time and tells when the lit part of the slot is over
module vfd_slot_timer
   import vfd_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // control
   input  wire logic       run,
   input  wire logic [1:0] slot_time_sel,
   input  wire logic [2:0] brightness_duty,
   // status
   output logic            slot_end,
   output logic            lit
);
   logic [11:0] cnt_q;
   logic [11:0] cnt_d;
   logic [11:0] last;
   logic [12:0] on_len;
   logic [3:0]  shift;
   logic [4:0]  on_16ths;

   // slot length fc/2^12 .. fc/2^9 selected by slot_time_sel
   assign shift    = 4'(`VFD_DIV_EXP_MAX) - {2'b00, slot_time_sel};  // R6
   assign last     = 12'(({1'b0, 12'hFFF}) >> (4'(`VFD_DIV_EXP_MAX) - shift));
   // lit part = (duty+9)/16 of slot: eight steps, 9/16..16/16
   assign on_16ths = 5'(brightness_duty) + 5'h09;                    // R5
   // 13 bits: a full-duty 4096-cycle slot would wrap to zero in 12
   assign on_len   = 13'((17'(last) + 17'h1) * 17'(on_16ths) >> 4);
   assign slot_end = run && (cnt_q == last);
   assign cnt_d    = (!run || slot_end) ? 12'h000 : cnt_q + 12'h001;

   // free-running slot counter while scanning
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 12'h000;
         lit   <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         lit   <= run && ({1'b0, cnt_d} < on_len);                  // R5
      end
   end
endmodule // vfd_slot_timer

// >>> test/vfd_scanner_sva.sv
`timescale 1ns/1ps
// slot order and slot length from the status outputs, claim mask and blanking seen at the pins
module vfd_scanner_sva
   import vfd_pkg::*;
(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        rst,
   // control inputs
   input wire logic        blank_set,
   input wire logic        blank_clr,
   input wire logic        low_power_entry,
   input wire logic [1:0]  slot_time_sel,
   input wire logic [4:0]  driver_pin_select,
   input wire logic [3:0]  scan_slot_count,
   input wire logic [11:0] buf_addr,
   // design outputs
   input wire logic [7:0]  buf_rdata,
   input wire logic [36:0] high_voltage_outputs,
   input wire logic [36:0] driver_claimed,
   input wire logic        blank_control,
   input wire logic        display_enable_key,
   input wire logic [3:0]  current_slot,
   input wire logic [2:0]  display_driver_status
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // claim mask per pin group, scan and step flags
   wire logic [36:0] mask_w = {{5{driver_pin_select[4]}},
      {8{driver_pin_select[3]}}, {8{driver_pin_select[2]}},
      {8{driver_pin_select[1]}}, {8{driver_pin_select[0]}}};
   wire logic scan_w = display_driver_status == VFD_SCAN;
   wire logic force_w = display_driver_status == VFD_FORCE;
   logic [3:0]  last_q;
   logic [12:0] cnt_q;
   logic        v_q;
   wire logic step_w = current_slot != last_q;
   // cycles spent in the slot; v_q marks a slot begun while scanning
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         last_q <= 4'h0;
         cnt_q <= 13'h0000;
         v_q <= 1'b0;
      end else begin
         last_q <= current_slot;
         cnt_q <= step_w ? 13'h0000 : cnt_q + 13'h0001;
         v_q <= scan_w & (v_q | step_w);
      end
   end
   property p_clr;
      blank_clr && !blank_set && !low_power_entry |=> !blank_control;
   endproperty
   a_clr: assert property (p_clr) else $error("blank stuck");
   property p_set; blank_set |=> blank_control ##1 !scan_w; endproperty
   a_set: assert property (p_set) else $error("no blank");
   property p_low;
      low_power_entry |=> blank_control && !display_enable_key;
   endproperty
   a_low: assert property (p_low) else $error("no forced blank");
   property p_dark;
      force_w [*2] |-> (high_voltage_outputs | driver_claimed) == 37'h0;
   endproperty
   a_dark: assert property (p_dark) else $error("lit in force");
   // the claim mask reaches the pins two cycles after the select input
   property p_mask;
      scan_w [*3] |-> driver_claimed == $past(mask_w, 2);
   endproperty
   a_mask: assert property (p_mask) else $error("claim mask");
   property p_step; v_q && step_w |-> current_slot ==
      (last_q == scan_slot_count ? 4'h0 : last_q + 4'h1); endproperty
   a_step: assert property (p_step) else $error("slot order");
   property p_len; v_q && step_w && scan_w |->
      cnt_q == (13'h1000 >> slot_time_sel) - 13'h0001; endproperty
   a_len: assert property (p_len) else $error("slot length");
   property p_win;
      buf_addr < 12'hF80 || buf_addr > 12'hFCF |=> buf_rdata == 8'h00;
   endproperty
   a_win: assert property (p_win) else $error("read outside");
endmodule // vfd_scanner_sva
bind vfd_scanner vfd_scanner_sva sva_u (.*);

// >>> test/vfd_tube_model.sv
`timescale 1ns/1ps
// tube grids and segments glow where a claimed pin drives high
module vfd_tube_model (
   // driver pins
   input wire logic        sys_clk,
   input wire logic [36:0] high_voltage_outputs,
   input wire logic [36:0] driver_claimed,
   // what the tube shows
   output logic [36:0]     glow
);
   // every driven bit of a slot lights at once
   always_ff @(posedge sys_clk) begin
      glow <= high_voltage_outputs & driver_claimed;
   end
endmodule // vfd_tube_model

// >>> test/vfd_scanner_tb.sv
`timescale 1ns/1ps
module vfd_scanner_tb
   import vfd_pkg::*;
;
   // settings held blanked from time zero
   logic sys_clk = 0, rst = 1, buf_wr = 0, blank_set = 1, blank_clr = 0;
   logic key_set = 0, low_power_entry = 0, blank_control, display_enable_key;
   logic [11:0] buf_addr = 12'h000;
   logic [7:0]  buf_wdata = 8'h00, buf_rdata;
   logic [1:0]  slot_time_sel = 2'h2;
   logic [4:0]  driver_pin_select = 5'h1F;
   logic [2:0]  brightness_duty = 3'h7, display_driver_status;
   logic [3:0]  scan_slot_count = 4'h3, current_slot;
   logic [36:0] port_latch = 37'h15_A5A5_A5A5, high_voltage_outputs;
   logic [36:0] driver_claimed, glow;
   int fails = 0, compares = 0, cyc = 0;
   vfd_scanner dut_u (.*);
   vfd_tube_model tube_u (.*);
   initial forever #20 sys_clk = ~sys_clk;
   // hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         $display("BAD %0t timeout", $time);
         end_sim();
      end
   end
   task end_sim();
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic tick(int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(logic [36:0] got, logic [36:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(logic [11:0] a, logic [7:0] d);
      buf_addr = a;
      buf_wdata = d;
      buf_wr = 1;
      tick();
   endtask
   task automatic rd(logic [11:0] a, logic [7:0] e);
      buf_addr = a;
      tick();
      chk(buf_rdata, e);
   endtask
   task automatic wslot(logic [3:0] n);
      for (int k = 0; k < 5000 && current_slot !== n; k++) tick();
      chk(current_slot, n);
   endtask
   task automatic unblank();
      blank_clr = 1;
      tick();
      blank_clr = 0;
      tick(3);
   endtask
   // column 0 carries one digit per slot in turn, the rest segments
   function automatic logic [7:0] pat(int c, int n);
      return (c == 0) ? 8'(1 << n) : 8'(c * 37 + n * 11 + 1);
   endfunction
   // expected pin levels for one slot, column c on pins 8c up
   function automatic logic [36:0] row(int n);
      logic [39:0] r;
      for (int c = 0; c < 5; c++) r[c*8 +: 8] = pat(c, n);
      return r[36:0];
   endfunction
   initial begin
      tick(16);
      rst = 0;
      blank_set = 0;
      tick();
      for (int c = 0; c < 5; c++)
         for (int n = 0; n < 4; n++)
            wr(12'(12'hF80 + c * 16 + n), pat(c, n));
      wr(12'hF7F, 8'hFF);
      buf_wr = 0;
      rd(12'hF7F, 8'h00);
      rd(12'hFD0, 8'h00);
      rd(12'hFC3, pat(4, 3));
      unblank();
      chk({blank_control, display_driver_status}, 4'h2);
      for (int k = 0; k < 6; k++) begin
         wslot(4'(k % 4));
         tick(3);
         chk(high_voltage_outputs, row(k % 4));
         chk(glow, row(k % 4));
      end
      blank_set = 1;
      tick();
      blank_set = 0;
      driver_pin_select = 5'h01;
      slot_time_sel = 2'h1;
      brightness_duty = 3'h0;
      scan_slot_count = 4'h1;
      tick();
      unblank();
      wslot(4'h1);
      tick(3);
      chk(high_voltage_outputs, row(1) & 37'hFF | port_latch & ~37'hFF);
      tick(1200);
      chk(high_voltage_outputs, port_latch & ~37'hFF);
      key_set = 1;
      tick();
      key_set = 0;
      low_power_entry = 1;
      tick();
      low_power_entry = 0;
      tick();
      chk({blank_control, display_enable_key}, 2'h2);
      tick(2);
      chk(display_driver_status, VFD_FORCE);
      chk(high_voltage_outputs, 37'h0);
      unblank();
      tick();
      chk(driver_claimed, 37'hFF);
      // longest slot at full duty is still lit 4000 cycles into slot 1
      blank_set = 1;
      tick();
      blank_set = 0;
      slot_time_sel = 2'h0;
      brightness_duty = 3'h7;
      tick();
      unblank();
      wslot(4'h1);
      tick(4000);
      chk(high_voltage_outputs, row(1) & 37'hFF | port_latch & ~37'hFF);
      end_sim();
   end
endmodule // vfd_scanner_tb
